// file: hw/tpg_defs.vh
`ifndef TPG_DEFS_VH
`define TPG_DEFS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define TPG_ADDR_CTRL 5'h1d
`define TPG_ADDR_PAYLOAD 5'h1e

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define TPG_BIT_ENABLE 15
`define TPG_BIT_RUN 14
`define TPG_BIT_CONT 13
`define TPG_LEN_HI 12
`define TPG_LEN_LO 11
`define TPG_BIT_GAP 10
`define TPG_DA_HI 9
`define TPG_DA_LO 6
`define TPG_SA_HI 5
`define TPG_SA_LO 2
`define TPG_BIT_RANDOM 1
`define TPG_BIT_BADFCS 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TPG_CTRL_RESET 16'h0040
`define TPG_PAYLOAD_RESET 16'h0000

// ----------------------------------------
// Frame lengths in bytes
// ----------------------------------------
`define TPG_LEN_125 14'h007d
`define TPG_LEN_64 14'h0040
`define TPG_LEN_1518 14'h05ee
`define TPG_LEN_JUMBO 14'h2710

// ----------------------------------------
// Packet counts
// ----------------------------------------
`define TPG_BLOCK_PKTS 32'h00002710
`define TPG_FIXED_PKTS 32'h01c9c380

// ----------------------------------------
// Gap times and cycle counts at 50 ns
// ----------------------------------------
`define TPG_CLK_NS 50
`define TPG_GAP_SHORT_NS 96
`define TPG_GAP_LONG_NS 8192
`define TPG_GAP_SHORT_CYC 16'h0002
`define TPG_GAP_LONG_CYC 16'h00a4

`endif

// file: hw/tpg_fifo.v
`timescale 1ns/1ps
`default_nettype none

module tpg_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire rst_i,
    input wire ce_i,
    // Write side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // Read side
    output wire out_valid_o,
    input wire out_ready_i,
    output reg [WIDTH-1:0] out_data_o
);

    // ----------------------------------------
    // Storage and pointers
    // ----------------------------------------
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr;
    reg [AW:0] rd_ptr;
    reg out_full;
    wire [AW:0] count = wr_ptr - rd_ptr;
    wire mem_empty = (count == {(AW+1){1'b0}});
    wire do_wr = in_valid_i && in_ready_o && ce_i;
    wire load = !mem_empty && (!out_full || out_ready_i) && ce_i;

    assign in_ready_o = (count != DEPTH[AW:0]) || (DEPTH == (1 << AW) && count[AW] == 1'b0);
    assign out_valid_o = out_full;

    always @(posedge ref_clk_i) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
            out_full <= 1'b0;
            out_data_o <= {WIDTH{1'b0}};
        end else if (ce_i) begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (load) begin
                out_data_o <= mem[rd_ptr[AW-1:0]];
                rd_ptr <= rd_ptr + 1'b1;
                out_full <= 1'b1;
            end else if (out_ready_i) begin
                out_full <= 1'b0;
            end
        end
    end

endmodule // tpg_fifo

`default_nettype wire

// file: hw/tpg_generator.v
// Notes on behaviour
// - Frames are generated only while enable and run bits are both set.
// - Continuous mode sends in blocks of 10,000; otherwise 30,000,000 packets then halt.
// - Continuous mode cleared while running ends at next 10,000-packet boundary.
// - Length field selects 125, 64, 1518 or 10,000 byte frames.
// - Gap bit selects 8,192 ns or 96 ns between frames.
// - Destination address low nibble comes from bits 9:6, default 0001.
// - Source address low nibble comes from bits 5:2, default 0000.
// - Bit 1 selects random payload or the fixed pattern register.
// - Bit 0 selects a corrupted or a correct frame check sequence.
// - Payload register holds a 16-bit pattern repeated across the payload.
// - Force low-power-idle, while the enable bit is set, sends idle symbols and ignores the MAC side.
`timescale 1ns/1ps
`default_nettype none
`include "tpg_defs.vh"

module tpg_generator #(
    parameter FIFO_DEPTH = 16,
    parameter [31:0] BLOCK_PKTS = `TPG_BLOCK_PKTS,
    parameter [31:0] FIXED_PKTS = `TPG_FIXED_PKTS,
    parameter [15:0] GAP_LONG_CYC = `TPG_GAP_LONG_CYC
) (
    // Clock, reset, enable
    input wire ref_clk_i,
    input wire rst_i,
    input wire ce_i,
    // Management register port
    input wire [4:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [15:0] reg_wdata_i,
    output reg [15:0] reg_rdata_o,
    // Low power idle control
    input wire force_lpi_i,
    // MAC side transmit
    input wire mac_tx_en_i,
    input wire [7:0] mac_txd_i,
    // Copper side transmit
    output reg media_tx_en_o,
    output reg [7:0] media_txd_o,
    output reg media_lpi_o,
    // Status
    output wire active_o,
    output reg [31:0] pkt_count_o
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [15:0] generator_control_word;
    reg [15:0] generator_payload_word;
    reg [15:0] snap_ctrl;
    reg [15:0] snap_payload;
    reg run_d;
    reg halted;
    reg force_lpi_s1;
    reg force_lpi_s2;

    wire run_req = generator_control_word[`TPG_BIT_ENABLE] && generator_control_word[`TPG_BIT_RUN];
    wire run_rise = run_req && !run_d;

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            force_lpi_s1 <= 1'b0;
            force_lpi_s2 <= 1'b0;
        end else if (ce_i) begin
            force_lpi_s1 <= force_lpi_i;
            force_lpi_s2 <= force_lpi_s1;
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            generator_control_word <= `TPG_CTRL_RESET;
            generator_payload_word <= `TPG_PAYLOAD_RESET;
            reg_rdata_o <= 16'h0000;
        end else if (ce_i) begin
            if (reg_wr_i && reg_addr_i == `TPG_ADDR_CTRL) begin
                generator_control_word <= reg_wdata_i;
            end
            if (reg_wr_i && reg_addr_i == `TPG_ADDR_PAYLOAD) begin
                generator_payload_word <= reg_wdata_i;
            end
            case (reg_addr_i)
                `TPG_ADDR_CTRL: reg_rdata_o <= generator_control_word;
                `TPG_ADDR_PAYLOAD: reg_rdata_o <= generator_payload_word;
                default: reg_rdata_o <= 16'h0000;
            endcase
        end
    end

    // ----------------------------------------
    // Snapshot on run start
    // ----------------------------------------
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            snap_ctrl <= `TPG_CTRL_RESET;
            snap_payload <= `TPG_PAYLOAD_RESET;
            run_d <= 1'b0;
        end else if (ce_i) begin
            run_d <= run_req;
            if (run_rise) begin
                snap_ctrl <= generator_control_word;
                snap_payload <= generator_payload_word;
            end
        end
    end

    // ----------------------------------------
    // Frame helpers
    // ----------------------------------------
    function [13:0] frame_len;
        input [1:0] sel;
        begin
            case (sel)
                2'b00: frame_len = `TPG_LEN_125;
                2'b01: frame_len = `TPG_LEN_64;
                2'b10: frame_len = `TPG_LEN_1518;
                default: frame_len = `TPG_LEN_JUMBO;
            endcase
        end
    endfunction

    function [31:0] crc_byte;
        input [31:0] crc;
        input [7:0] d;
        integer k;
        reg [31:0] c;
        begin
            c = crc;
            for (k = 0; k < 8; k = k + 1) begin
                if (c[0] ^ d[k]) begin
                    c = (c >> 1) ^ 32'hedb88320;
                end else begin
                    c = c >> 1;
                end
            end
            crc_byte = c;
        end
    endfunction

    // ----------------------------------------
    // Byte producer state machine
    // ----------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_PRE = 2'h1;
    localparam ST_BODY = 2'h2;
    localparam ST_GAP = 2'h3;

    reg [1:0] state;
    reg [13:0] byte_idx;
    reg [15:0] gap_cnt;
    reg [31:0] crc;
    reg [15:0] lfsr;
    reg [13:0] block_cnt;
    wire fifo_ready;
    reg prod_valid;
    reg [8:0] prod_data;
    wire [13:0] flen = frame_len(snap_ctrl[`TPG_LEN_HI:`TPG_LEN_LO]);
    wire [13:0] body_len = flen - 14'h0004;
    wire [31:0] fcs = snap_ctrl[`TPG_BIT_BADFCS] ? crc : ~crc;
    wire [15:0] gap_len = snap_ctrl[`TPG_BIT_GAP] ? GAP_LONG_CYC : `TPG_GAP_SHORT_CYC;
    wire at_block_end = (block_cnt == BLOCK_PKTS[13:0] - 14'h0001);
    wire stop_now = snap_ctrl[`TPG_BIT_CONT] ?
        (!generator_control_word[`TPG_BIT_CONT] && at_block_end) :
        (pkt_count_o == FIXED_PKTS - 32'h00000001);
    wire gen_on = run_req && !halted;

    assign active_o = (state != ST_IDLE);

    always @* begin
        prod_valid = (state == ST_PRE) || (state == ST_BODY);
        prod_data = 9'h000;
        if (state == ST_PRE) begin
            prod_data = (byte_idx == 14'h0007) ? 9'h0d5 : 9'h055;
        end else if (byte_idx < 14'h0006) begin
            prod_data = (byte_idx == 14'h0005) ? {1'b0, 4'hf, snap_ctrl[`TPG_DA_HI:`TPG_DA_LO]} : 9'h0ff;
        end else if (byte_idx < 14'h000c) begin
            prod_data = (byte_idx == 14'h000b) ? {1'b0, 4'hf, snap_ctrl[`TPG_SA_HI:`TPG_SA_LO]} : 9'h0ff;
        end else if (byte_idx < body_len) begin
            if (snap_ctrl[`TPG_BIT_RANDOM]) begin
                prod_data = {1'b0, lfsr[7:0]};
            end else begin
                prod_data = {1'b0, byte_idx[0] ? snap_payload[7:0] : snap_payload[15:8]};
            end
        end else begin
            case (byte_idx - body_len)
                14'h0000: prod_data = {1'b0, fcs[7:0]};
                14'h0001: prod_data = {1'b0, fcs[15:8]};
                14'h0002: prod_data = {1'b0, fcs[23:16]};
                default: prod_data = {1'b1, fcs[31:24]};
            endcase
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            byte_idx <= 14'h0000;
            gap_cnt <= 16'h0000;
            crc <= 32'hffffffff;
            lfsr <= 16'hace1;
            block_cnt <= 14'h0000;
            pkt_count_o <= 32'h00000000;
            halted <= 1'b0;
        end else if (ce_i) begin
            if (!run_req) begin
                halted <= 1'b0;
            end
            if (prod_valid && fifo_ready && state == ST_BODY && byte_idx >= 14'h000c && byte_idx < body_len) begin
                lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            end
            case (state)
                ST_IDLE: begin
                    if (gen_on && !run_rise) begin
                        state <= ST_PRE;
                        byte_idx <= 14'h0000;
                        crc <= 32'hffffffff;
                    end
                    if (run_rise) begin
                        pkt_count_o <= 32'h00000000;
                        block_cnt <= 14'h0000;
                    end
                end
                ST_PRE: begin
                    if (fifo_ready) begin
                        byte_idx <= (byte_idx == 14'h0007) ? 14'h0000 : byte_idx + 14'h0001;
                        if (byte_idx == 14'h0007) begin
                            state <= ST_BODY;
                        end
                    end
                end
                ST_BODY: begin
                    if (fifo_ready) begin
                        if (byte_idx < body_len) begin
                            crc <= crc_byte(crc, prod_data[7:0]);
                        end
                        byte_idx <= byte_idx + 14'h0001;
                        if (prod_data[8]) begin
                            state <= ST_GAP;
                            gap_cnt <= 16'h0000;
                            pkt_count_o <= pkt_count_o + 32'h00000001;
                            block_cnt <= at_block_end ? 14'h0000 : block_cnt + 14'h0001;
                            if (stop_now) begin
                                halted <= 1'b1;
                            end
                        end
                    end
                end
                ST_GAP: begin
                    gap_cnt <= gap_cnt + 16'h0001;
                    if (gap_cnt >= gap_len - 16'h0001) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Frame buffer toward media
    // ----------------------------------------
    wire out_valid;
    wire [8:0] out_data;
    reg in_frame;

    tpg_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH),
        .AW(4)
    ) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .in_valid_i(prod_valid),
        .in_ready_o(fifo_ready),
        .in_data_i(prod_data),
        .out_valid_o(out_valid),
        .out_ready_i(1'b1),
        .out_data_o(out_data)
    );

    // ----------------------------------------
    // Media transmit mux
    // ----------------------------------------
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            media_tx_en_o <= 1'b0;
            media_txd_o <= 8'h00;
            media_lpi_o <= 1'b0;
            in_frame <= 1'b0;
        end else if (ce_i) begin
            if (out_valid) begin
                in_frame <= !out_data[8];
            end
            if (force_lpi_s2 && generator_control_word[`TPG_BIT_ENABLE]) begin
                media_lpi_o <= 1'b1;
                media_tx_en_o <= 1'b0;
                media_txd_o <= 8'h00;
            end else if (gen_on || active_o || out_valid || in_frame) begin
                media_lpi_o <= 1'b0;
                media_tx_en_o <= out_valid;
                media_txd_o <= out_valid ? out_data[7:0] : 8'h00;
            end else begin
                media_lpi_o <= 1'b0;
                media_tx_en_o <= mac_tx_en_i;
                media_txd_o <= mac_txd_i;
            end
        end
    end

endmodule // tpg_generator

`default_nettype wire

// file: verif/tpg_gen_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tpg_gen_properties #(
    parameter [31:0] FIXED_PKTS = 32'h0000000a,
    parameter [15:0] GAP_LONG_CYC = 16'h0008
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire rst_i,
    input wire ce_i,
    // Registers
    input wire [4:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [15:0] reg_wdata_i,
    input wire [15:0] reg_rdata_o,
    // Copper side
    input wire force_lpi_i,
    input wire media_tx_en_o,
    input wire [7:0] media_txd_o,
    input wire media_lpi_o,
    input wire [31:0] pkt_count_o
);
    logic [15:0] ctrl = 16'h0040;
    logic [15:0] snap = 16'h0000;
    logic [15:0] nb = 16'h0000;
    logic [15:0] ic = 16'h0000;
    logic [15:0] flen;
    logic rq = 1'b0;
    logic run;
    // ------
    // Shadow state
    // ------
    assign run = ctrl[15] & ctrl[14];
    always_comb begin
        case (snap[12:11])
            2'b00: flen = 16'h007d;
            2'b01: flen = 16'h0040;
            2'b10: flen = 16'h05ee;
            default: flen = 16'h2710;
        endcase
    end
    always_ff @(posedge ref_clk_i) begin
        nb <= media_tx_en_o ? nb + 16'h0001 : 16'h0000;
        ic <= media_tx_en_o ? 16'h0000 : (ic == 16'hffff ? ic : ic + 16'h0001);
        if (rst_i) begin
            ctrl <= 16'h0040;
            rq <= 1'b0;
        end else if (ce_i) begin
            rq <= run;
            if (reg_wr_i && reg_addr_i == 5'h1d) ctrl <= reg_wdata_i;
            if (run && !rq) snap <= ctrl;
        end
    end
    // ------
    // Checks
    // ------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !media_tx_en_o && pkt_count_o == 32'h0)
        else $error("outputs not cleared by reset");
    a_read_ctrl: assert property ((reg_addr_i == 5'h1d && !reg_wr_i)[*2] |=> reg_rdata_o == ctrl)
        else $error("control read mismatch");
    a_read_unmapped: assert property (reg_addr_i != 5'h1d && reg_addr_i != 5'h1e |=> reg_rdata_o == 16'h0)
        else $error("unmapped read not zero");
    a_preamble_bytes: assert property ($rose(media_tx_en_o) && run |-> (media_tx_en_o && media_txd_o == 8'h55)[*7]
        ##1 (media_tx_en_o && media_txd_o == 8'hd5)) else $error("bad preamble");
    a_addr_nibbles: assert property ($rose(media_tx_en_o) && run |-> ##13 media_txd_o == {4'hf, snap[9:6]}
        ##6 media_txd_o == {4'hf, snap[5:2]}) else $error("bad address byte");
    a_frame_len: assert property ($fell(media_tx_en_o) && run |-> nb == flen + 16'h0008)
        else $error("bad frame length");
    a_gap_min: assert property ($rose(media_tx_en_o) && run |-> ic >= (snap[10] ? GAP_LONG_CYC : 16'h0002))
        else $error("gap too short");
    a_halt_limit: assert property (run && !snap[13] |-> pkt_count_o <= FIXED_PKTS)
        else $error("too many packets");
    a_lpi_on: assert property ((force_lpi_i && ctrl[15])[*4] |-> media_lpi_o)
        else $error("idle not forced");
    a_lpi_off: assert property ((!force_lpi_i)[*4] |-> !media_lpi_o)
        else $error("idle forced without request");
endmodule // tpg_gen_properties
bind tpg_generator tpg_gen_properties #(.FIXED_PKTS(FIXED_PKTS), .GAP_LONG_CYC(GAP_LONG_CYC)) u_props (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .force_lpi_i(force_lpi_i), .media_tx_en_o(media_tx_en_o),
    .media_txd_o(media_txd_o), .media_lpi_o(media_lpi_o), .pkt_count_o(pkt_count_o));
`default_nettype wire

// file: verif/tpg_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module tpg_link_partner (
    // Copper side
    input wire logic clk_i,
    input wire logic en_i,
    input wire logic [7:0] d_i
);
    logic [7:0] mem [0:10015];
    int n = 0;
    int len = 0;
    int frames = 0;
    int gap = 0;
    int min_gap = 100000;
    // ------
    // Frame capture
    // ------
    always @(posedge clk_i) begin
        if (en_i === 1'b1) begin
            if (n == 0 && frames > 0 && gap < min_gap) min_gap = gap;
            if (n < 10016) mem[n] = d_i;
            n = n + 1;
            gap = 0;
        end else begin
            if (n > 0) begin
                len = n;
                frames = frames + 1;
            end
            n = 0;
            gap = gap + 1;
        end
    end
endmodule // tpg_link_partner
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [4:0] reg_addr_i = 5'h00;
    logic reg_wr_i = 1'b0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic force_lpi_i = 1'b0;
    logic mac_tx_en_i = 1'b0;
    logic [7:0] mac_txd_i = 8'h00;
    wire [15:0] reg_rdata_o;
    wire media_tx_en_o;
    wire [7:0] media_txd_o;
    wire media_lpi_o;
    wire active_o;
    wire [31:0] pkt_count_o;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    tpg_generator #(.BLOCK_PKTS(32'h4), .FIXED_PKTS(32'ha), .GAP_LONG_CYC(16'h8)) uut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .force_lpi_i(force_lpi_i), .mac_tx_en_i(mac_tx_en_i),
        .mac_txd_i(mac_txd_i), .media_tx_en_o(media_tx_en_o), .media_txd_o(media_txd_o), .media_lpi_o(media_lpi_o),
        .active_o(active_o), .pkt_count_o(pkt_count_o));
    tpg_link_partner lp (.clk_i(ref_clk_i), .en_i(media_tx_en_o), .d_i(media_txd_o));
    // ------
    // Helpers
    // ------
    initial forever #25 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 90000) begin
            failures++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tk(input int k);
        repeat (k) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        tk(1);
        reg_wr_i = 1'b0;
        tk(1);
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        reg_addr_i = a;
        tk(2);
        chk("read data", {16'h0, e}, {16'h0, reg_rdata_o});
    endtask
    task automatic go(input logic [15:0] c);
        lp.frames = 0;
        lp.min_gap = 100000;
        wr(5'h1d, c);
    endtask
    function automatic logic [31:0] crc();
        logic [31:0] c;
        c = 32'hffffffff;
        for (int i = 8; i < lp.len - 4; i++) begin
            c = c ^ {24'h0, lp.mem[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
        end
        return c;
    endfunction
    function automatic logic [31:0] fcs();
        return {lp.mem[lp.len-1], lp.mem[lp.len-2], lp.mem[lp.len-3], lp.mem[lp.len-4]};
    endfunction
    // ------
    // Scenarios
    // ------
    task automatic t_regs;
        rd(5'h1d, 16'h0040);
        rd(5'h1e, 16'h0000);
        rd(5'h00, 16'h0000);
        wr(5'h1e, 16'ha5c3);
        rd(5'h1e, 16'ha5c3);
        ce_i = 1'b0;
        wr(5'h1e, 16'hffff);
        ce_i = 1'b1;
        rd(5'h1e, 16'ha5c3);
    endtask
    task automatic t_fixed;
        wr(5'h1e, 16'h3c96);
        go(16'hc8f0);
        while (lp.frames < 10) tk(1);
        tk(300);
        chk("frames", 10, lp.frames);
        chk("count", 10, pkt_count_o);
        chk("length", 72, lp.len);
        chk("dest", 8'hf3, lp.mem[13]);
        chk("src", 8'hfc, lp.mem[19]);
        chk("pattern", 16'h3c96, {lp.mem[20], lp.mem[21]});
        chk("good fcs", ~crc(), fcs());
        chk("short gap", 1, lp.min_gap >= 2);
        wr(5'h1e, 16'h1234);
        wr(5'h1d, 16'hc541);
        tk(300);
        chk("frames held", 10, lp.frames);
        wr(5'h1d, 16'h8541);
        go(16'hc541);
        while (lp.frames < 10) tk(1);
        tk(300);
        chk("length", 133, lp.len);
        chk("dest", 8'hf5, lp.mem[13]);
        chk("pattern", 16'h1234, {lp.mem[20], lp.mem[21]});
        chk("bad fcs", crc(), fcs());
        chk("long gap", 1, lp.min_gap >= 8);
        wr(5'h1d, 16'h0000);
    endtask
    task automatic t_cont;
        int lens [4] = '{125, 64, 1518, 10000};
        for (int k = 0; k < 4; k++) begin
            go(16'he042 | (16'(k) << 11));
            while (lp.n == 0) tk(1);
            chk("active", 1, active_o);
            wr(5'h1d, 16'hc042 | (16'(k) << 11));
            while (lp.frames < 4) tk(1);
            tk(300);
            chk("block stop", 4, lp.frames);
            chk("idle", 0, active_o);
            chk("length", lens[k] + 8, lp.len);
            chk("random fcs", ~crc(), fcs());
            chk("random data", 1, {lp.mem[20], lp.mem[21], lp.mem[22], lp.mem[23]} !== 32'h12341234);
            wr(5'h1d, 16'h0000);
        end
    endtask
    task automatic t_mac_lpi;
        mac_txd_i = 8'h5a;
        mac_tx_en_i = 1'b1;
        tk(8);
        chk("mac pass", 9'h15a, {media_tx_en_o, media_txd_o});
        wr(5'h1d, 16'h8040);
        force_lpi_i = 1'b1;
        tk(8);
        chk("lpi", 2'b10, {media_lpi_o, media_tx_en_o});
        force_lpi_i = 1'b0;
        tk(8);
        wr(5'h1d, 16'h0040);
        chk("lpi off", 0, media_lpi_o);
        mac_tx_en_i = 1'b0;
    endtask
    initial begin
        repeat (16) @(posedge ref_clk_i);
        #1;
        rst_i = 1'b0;
        t_regs();
        t_fixed();
        t_cont();
        t_mac_lpi();
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
